//--- logic/pem_pkg.sv
package pem_pkg;
   // Register offsets (8-bit register space reached through the serial slave)
   localparam logic [7:0] OFF_TIMER_CFG = 8'h11;
   localparam logic [7:0] OFF_IND_STATUS = 8'h12;
   localparam logic [7:0] OFF_MAXDUTY_LO = 8'h13;
   localparam logic [7:0] OFF_MAXDUTY_HI = 8'h14;
   localparam logic [7:0] OFF_OC_LO = 8'h15;
   localparam logic [7:0] OFF_OC_HI = 8'h16;
   localparam logic [7:0] OFF_T1_LO = 8'h17;
   localparam logic [7:0] OFF_T1_HI = 8'h18;
   localparam logic [7:0] OFF_T2_LO = 8'h19;
   localparam logic [7:0] OFF_T2_HI = 8'h1A;
   localparam logic [7:0] OFF_LINK_FLAGS = 8'h1B;
   localparam logic [7:0] OFF_PROT_CTRL = 8'h1C;
   localparam logic [7:0] OFF_PROT_FLAGS = 8'h1D;
   localparam logic [7:0] OFF_PROT_EN = 8'h1F;
   localparam logic [7:0] OFF_T1_HYST = 8'h29;
   localparam logic [7:0] OFF_T2_HYST = 8'h2A;
   localparam logic [7:0] OFF_DLY_MULT = 8'h36;
   // Field positions
   localparam int TMR_DIS_BIT = 5;
   localparam int TMR_SEL_LSB = 6;
   localparam int TMO_FLAG_BIT = 5;
   localparam int LNK_RST_BIT = 0;
   localparam int LNK_PKT_BIT = 1;
   localparam int LNK_WR_BIT = 2;
   localparam int LNK_RD_BIT = 3;
   localparam int LNK_RSTRT_BIT = 4;
   localparam int LNK_EN_BIT = 7;
   localparam int PRT_RST_BIT = 0;
   localparam int PRT_EN_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Timing at 125 MHz
   localparam int CLK_MHZ = 125;
   localparam int US_FAST = 1;
   localparam int FAST_CYC = US_FAST * CLK_MHZ;
   localparam int MS_STEP = 1;
   localparam int MS_CYC = MS_STEP * 1000 * CLK_MHZ;
   localparam int OV_BLANK_MS = 16;
   localparam int OV_QUAL_MS = 4;
   localparam int QUAL_UNIT_MS = 16;
   localparam int TMO_MIN_0 = 198;
   localparam int TMO_MIN_1 = 264;
   localparam int TMO_MIN_2 = 330;
   localparam int TMO_MIN_3 = 396;
   localparam int MS_PER_MIN = 60000;
   localparam int PROT_LIMIT = 8;

   // Operation mode of the transmitter
   typedef enum logic [2:0] {
      PEM_MODE_ALONE = 3'b001,
      PEM_MODE_ATPC = 3'b010,
      PEM_MODE_MCU = 3'b100
   } pem_mode_e;

   // Supervisor state
   typedef enum logic [3:0] {
      PEM_ST_INIT = 4'b0001,
      PEM_ST_DRIVE = 4'b0010,
      PEM_ST_PAUSE = 4'b0100,
      PEM_ST_HALT = 4'b1000
   } pem_state_e;

   // Register access strobes from the serial slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pem_reg_req_s;

   // Analog comparator and converter results
   typedef struct packed {
      logic short_det;
      logic ov_high;
      logic ov_low;
      logic [11:0] current_code;
      logic [11:0] therm1_code;
      logic [11:0] therm2_code;
   } pem_sense_s;

   // Wireless link events, one-cycle pulses
   typedef struct packed {
      logic pkt_rx;
      logic wr_done;
      logic rd_done;
      logic access_fail;
   } pem_link_s;
endpackage

//--- logic/pem_qual.sv
`timescale 1ns/1ps
`default_nettype none
// Qualifies a condition: it must hold for the whole window before det rises
module pem_qual #(
   parameter int CW = 36
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cond,
   input wire logic [CW-1:0] limit,
   output logic det
);
   logic [CW-1:0] cnt_reg;
   wire logic reached = (cnt_reg >= limit);

   // Counter restarts whenever the condition drops, so glitches never add up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         det <= 1'b0;
      end else begin
         cnt_reg <= cond ? (reached ? cnt_reg : cnt_reg + 1'b1) : '0;
         det <= cond && reached;
      end
   end
endmodule
`default_nettype wire

//--- logic/pem_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pem_monitor
   import pem_pkg::*;
#(
   parameter int TMO_MS_0 = TMO_MIN_0 * MS_PER_MIN,
   parameter int TMO_MS_1 = TMO_MIN_1 * MS_PER_MIN,
   parameter int TMO_MS_2 = TMO_MIN_2 * MS_PER_MIN,
   parameter int TMO_MS_3 = TMO_MIN_3 * MS_PER_MIN,
   parameter int MS_TICK = MS_CYC,
   parameter int FAULT_LIMIT = PROT_LIMIT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic supply_low,
   input wire logic standby_n,
   input wire pem_pkg::pem_mode_e mode,
   input wire logic drive_request,
   input wire pem_pkg::pem_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   input wire pem_pkg::pem_sense_s sense,
   input wire logic [9:0] duty_now,
   input wire pem_pkg::pem_link_s link,
   output logic driver_enable,
   output logic restore_initial_duty,
   output logic alert_n
);
   import pem_pkg::*;

   // Reset: any of the three sources holds the logic in power-on reset
   logic sb_s1, sb_s2, sb_s3, uv_s1, uv_s2, uv_s3;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {sb_s1, sb_s2, sb_s3} <= 3'h0;
         {uv_s1, uv_s2, uv_s3} <= 3'h7;
      end else begin
         {sb_s1, sb_s2, sb_s3} <= {standby_n, sb_s1, sb_s2};
         {uv_s1, uv_s2, uv_s3} <= {supply_low, uv_s1, uv_s2};
      end
   end
   wire logic sb_low = !sb_s2 && !sb_s3;
   wire logic uv_act = uv_s2 && uv_s3;
   wire logic por = sb_low || uv_act;
   // Synchronous power-on reset taken from the qualified inputs
   logic por_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) por_reg <= 1'b1;
      else por_reg <= por;
   end

   // Registers
   logic [7:0] tmr_cfg_reg, mxd_lo_reg, mxd_hi_reg, oc_lo_reg, oc_hi_reg;
   logic [7:0] t1_lo_reg, t1_hi_reg, t2_lo_reg, t2_hi_reg, t1_hy_reg, t2_hy_reg;
   logic [7:0] prt_en_reg, mult_reg;
   logic lnk_en_reg, prt_en_all_reg, tmo_flag_reg;
   logic [3:0] lnk_flag_reg;
   logic [5:0] prt_flag_reg;
   wire logic wr = reg_req.wr && !por_reg;
   wire logic wr_lnk_rst = wr && reg_req.addr == OFF_LINK_FLAGS && reg_req.wdata[LNK_RST_BIT];
   wire logic wr_prt_rst = wr && reg_req.addr == OFF_PROT_CTRL && reg_req.wdata[PRT_RST_BIT];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {tmr_cfg_reg, mxd_lo_reg, mxd_hi_reg, oc_lo_reg, oc_hi_reg} <= {5{RST_BYTE}};
         {t1_lo_reg, t1_hi_reg, t2_lo_reg, t2_hi_reg, t1_hy_reg, t2_hy_reg} <= {6{RST_BYTE}};
         {prt_en_reg, mult_reg} <= {2{RST_BYTE}};
         lnk_en_reg <= 1'b0;
         prt_en_all_reg <= 1'b0;
      end else if (por_reg) begin
         {tmr_cfg_reg, mxd_lo_reg, mxd_hi_reg, oc_lo_reg, oc_hi_reg} <= {5{RST_BYTE}};
         {t1_lo_reg, t1_hi_reg, t2_lo_reg, t2_hi_reg, t1_hy_reg, t2_hy_reg} <= {6{RST_BYTE}};
         {prt_en_reg, mult_reg} <= {2{RST_BYTE}};
         lnk_en_reg <= 1'b0;
         prt_en_all_reg <= 1'b0;
      end else if (wr) begin
         unique case (reg_req.addr)
            OFF_TIMER_CFG: tmr_cfg_reg <= reg_req.wdata;
            OFF_MAXDUTY_LO: mxd_lo_reg <= reg_req.wdata;
            OFF_MAXDUTY_HI: mxd_hi_reg <= reg_req.wdata;
            OFF_OC_LO: oc_lo_reg <= reg_req.wdata;
            OFF_OC_HI: oc_hi_reg <= reg_req.wdata;
            OFF_T1_LO: t1_lo_reg <= reg_req.wdata;
            OFF_T1_HI: t1_hi_reg <= reg_req.wdata;
            OFF_T2_LO: t2_lo_reg <= reg_req.wdata;
            OFF_T2_HI: t2_hi_reg <= reg_req.wdata;
            OFF_LINK_FLAGS: lnk_en_reg <= reg_req.wdata[LNK_EN_BIT];
            OFF_PROT_CTRL: prt_en_all_reg <= reg_req.wdata[PRT_EN_BIT];
            OFF_PROT_EN: prt_en_reg <= reg_req.wdata;
            OFF_T1_HYST: t1_hy_reg <= reg_req.wdata;
            OFF_T2_HYST: t2_hy_reg <= reg_req.wdata;
            OFF_DLY_MULT: mult_reg <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // Limits assembled from register pairs
   wire logic [11:0] oc_lim = {oc_hi_reg[3:0], oc_lo_reg};
   wire logic [11:0] t1_lim = {t1_hi_reg[3:0], t1_lo_reg};
   wire logic [11:0] t2_lim = {t2_hi_reg[3:0], t2_lo_reg};
   wire logic [9:0] mxd_lim = {mxd_hi_reg[1:0], mxd_lo_reg};

   // Supervisor state
   pem_state_e st_reg, st_next;
   wire logic in_drive = (st_reg == PEM_ST_DRIVE);
   wire logic atpc = (mode == PEM_MODE_ATPC);

   // Millisecond tick shared by the blanking, over-voltage and session timers
   logic [31:0] ms_cnt_reg;
   wire logic ms_tick = (ms_cnt_reg == 32'(MS_TICK - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ms_cnt_reg <= 32'h0;
      else ms_cnt_reg <= (ms_tick || por_reg) ? 32'h0 : ms_cnt_reg + 32'h1;
   end

   // Over-voltage blanking after reset release, then qualification window
   logic [4:0] blank_reg;
   logic [2:0] ov_ms_reg;
   logic ov_det_reg;
   wire logic blank_done = (blank_reg == 5'(OV_BLANK_MS));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         blank_reg <= 5'h0;
         ov_ms_reg <= 3'h0;
         ov_det_reg <= 1'b0;
      end else if (por_reg) begin
         blank_reg <= 5'h0;
         ov_ms_reg <= 3'h0;
         ov_det_reg <= 1'b0;
      end else begin
         if (ms_tick && !blank_done) blank_reg <= blank_reg + 5'h1;
         if (!blank_done || !sense.ov_high) ov_ms_reg <= 3'h0;
         else if (ms_tick && ov_ms_reg != 3'(OV_QUAL_MS)) ov_ms_reg <= ov_ms_reg + 3'h1;
         if (ov_ms_reg == 3'(OV_QUAL_MS)) ov_det_reg <= 1'b1;
         else if (sense.ov_low) ov_det_reg <= 1'b0;
      end
   end

   // Fault qualification: short circuit and maximum duty within 1 us, overcurrent and thermal over 16 ms multiples
   wire logic oc_cond = in_drive && (sense.current_code > oc_lim);
   wire logic t1_set = sense.therm1_code > t1_lim;
   wire logic t2_set = sense.therm2_code > t2_lim;
   logic t1_hot_reg, t2_hot_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) {t1_hot_reg, t2_hot_reg} <= 2'b00;
      else if (por_reg) {t1_hot_reg, t2_hot_reg} <= 2'b00;
      else begin
         // Hysteresis keeps the level from chattering near the limit
         if (t1_set) t1_hot_reg <= 1'b1;
         else if ({1'b0, sense.therm1_code} + {5'h0, t1_hy_reg} < {1'b0, t1_lim}) t1_hot_reg <= 1'b0;
         if (t2_set) t2_hot_reg <= 1'b1;
         else if ({1'b0, sense.therm2_code} + {5'h0, t2_hy_reg} < {1'b0, t2_lim}) t2_hot_reg <= 1'b0;
      end
   end
   wire logic [35:0] slow_unit = 36'(QUAL_UNIT_MS) * 36'(MS_TICK);
   wire logic [35:0] oc_win = slow_unit * {32'h0, mult_reg[3:0]};
   wire logic [35:0] th_win = slow_unit * {32'h0, mult_reg[7:4]};
   wire logic oc_det, t1_det, t2_det, sc_det, md_det;
   pem_qual u_oc (.clk(clk), .rstn(rstn), .cond(oc_cond), .limit(oc_win), .det(oc_det));
   pem_qual u_t1 (.clk(clk), .rstn(rstn), .cond(in_drive && t1_hot_reg), .limit(th_win), .det(t1_det));
   pem_qual u_t2 (.clk(clk), .rstn(rstn), .cond(in_drive && t2_hot_reg), .limit(th_win), .det(t2_det));
   pem_qual u_sc (.clk(clk), .rstn(rstn), .cond(in_drive && sense.short_det),
      .limit(36'(FAST_CYC - 2)), .det(sc_det));
   pem_qual u_md (.clk(clk), .rstn(rstn), .cond(in_drive && duty_now > mxd_lim),
      .limit(36'(FAST_CYC - 2)), .det(md_det));

   // Latching faults and recoverable faults
   wire logic latch_fault = sc_det || oc_det;
   wire logic soft_fault = ov_det_reg || t1_det || t2_det || md_det;
   wire logic link_err = atpc && link.access_fail && in_drive;
   wire logic soft_clear = !ov_det_reg && !t1_hot_reg && !t2_hot_reg && !(duty_now > mxd_lim);

   // Session timer runs only in drive mode
   logic [31:0] sess_ms_reg;
   logic [31:0] tmo_ms;
   always_comb begin
      unique case (tmr_cfg_reg[TMR_SEL_LSB +: 2])
         2'd0: tmo_ms = 32'(TMO_MS_0);
         2'd1: tmo_ms = 32'(TMO_MS_1);
         2'd2: tmo_ms = 32'(TMO_MS_2);
         default: tmo_ms = 32'(TMO_MS_3);
      endcase
   end
   wire logic tmr_on = !tmr_cfg_reg[TMR_DIS_BIT];
   wire logic timeout = tmr_on && in_drive && sess_ms_reg >= tmo_ms;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) sess_ms_reg <= 32'h0;
      else if (por_reg || st_reg == PEM_ST_INIT) sess_ms_reg <= 32'h0;
      else if (in_drive && ms_tick) sess_ms_reg <= sess_ms_reg + 32'h1;
   end

   // Fault counter; the last allowed fault stops delivery for good
   logic [7:0] fault_cnt_reg;
   wire logic restart_evt = in_drive && (soft_fault || link_err);
   wire logic count_full = (fault_cnt_reg + 8'h1 >= 8'(FAULT_LIMIT));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) fault_cnt_reg <= 8'h0;
      else if (por_reg) fault_cnt_reg <= 8'h0;
      else if (restart_evt && !count_full) fault_cnt_reg <= fault_cnt_reg + 8'h1;
   end

   // State machine
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         PEM_ST_INIT: if (drive_request && !ov_det_reg) st_next = PEM_ST_DRIVE;
         PEM_ST_DRIVE: begin
            if (latch_fault || timeout) st_next = PEM_ST_HALT;
            else if (restart_evt) st_next = count_full ? PEM_ST_HALT : PEM_ST_PAUSE;
         end
         PEM_ST_PAUSE: if (atpc || soft_clear) st_next = PEM_ST_DRIVE;
         PEM_ST_HALT: st_next = PEM_ST_HALT;
      endcase
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) st_reg <= PEM_ST_INIT;
      else if (por_reg) st_reg <= PEM_ST_INIT;
      else st_reg <= st_next;
   end

   // Event flags: a new event wins over a reset in the same cycle
   wire logic [5:0] prt_evt = {oc_det, md_det, sc_det, ov_det_reg, t2_det, t1_det};
   wire logic [3:0] lnk_evt = {restart_evt && (atpc || link_err), link.rd_done && atpc,
      link.wr_done && atpc, link.pkt_rx && mode == PEM_MODE_MCU};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prt_flag_reg <= 6'h0;
         lnk_flag_reg <= 4'h0;
         tmo_flag_reg <= 1'b0;
      end else if (por_reg) begin
         prt_flag_reg <= 6'h0;
         lnk_flag_reg <= 4'h0;
         tmo_flag_reg <= 1'b0;
      end else begin
         prt_flag_reg <= prt_evt | (wr_prt_rst ? 6'h0 : prt_flag_reg);
         lnk_flag_reg <= lnk_evt | (wr_lnk_rst ? 4'h0 : lnk_flag_reg);
         if (timeout) tmo_flag_reg <= 1'b1;
      end
   end

   // Alert pin gathers enabled protection flags and the packet, write and read done link flags; write and read done alert without an enable
   wire logic prt_alert = prt_en_all_reg && |(prt_flag_reg & prt_en_reg[5:0]);
   wire logic lnk_alert = lnk_en_reg && |lnk_flag_reg[2:0];
   wire logic wrd_alert = |lnk_flag_reg[2:1];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) alert_n <= 1'b1;
      else alert_n <= !(prt_alert || lnk_alert || wrd_alert);
   end

   // Driver control outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         driver_enable <= 1'b0;
         restore_initial_duty <= 1'b0;
      end else begin
         driver_enable <= (st_next == PEM_ST_DRIVE) && !por_reg;
         restore_initial_duty <= (st_reg == PEM_ST_PAUSE) && atpc;
      end
   end

   // Read mux; unmapped offsets read as zero
   wire logic [7:0] rd_ind = {2'b00, tmo_flag_reg, 5'h00};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) reg_rdata <= 8'h00;
      else if (reg_req.rd) begin
         unique case (reg_req.addr)
            OFF_TIMER_CFG: reg_rdata <= tmr_cfg_reg;
            OFF_IND_STATUS: reg_rdata <= rd_ind;
            OFF_MAXDUTY_LO: reg_rdata <= mxd_lo_reg;
            OFF_MAXDUTY_HI: reg_rdata <= mxd_hi_reg;
            OFF_OC_LO: reg_rdata <= oc_lo_reg;
            OFF_OC_HI: reg_rdata <= oc_hi_reg;
            OFF_T1_LO: reg_rdata <= t1_lo_reg;
            OFF_T1_HI: reg_rdata <= t1_hi_reg;
            OFF_T2_LO: reg_rdata <= t2_lo_reg;
            OFF_T2_HI: reg_rdata <= t2_hi_reg;
            OFF_LINK_FLAGS: reg_rdata <= {lnk_en_reg, 2'b00, lnk_flag_reg, 1'b0};
            OFF_PROT_CTRL: reg_rdata <= {6'h00, prt_en_all_reg, 1'b0};
            OFF_PROT_FLAGS: reg_rdata <= {2'b00, prt_flag_reg};
            OFF_PROT_EN: reg_rdata <= prt_en_reg;
            OFF_T1_HYST: reg_rdata <= t1_hy_reg;
            OFF_T2_HYST: reg_rdata <= t2_hy_reg;
            OFF_DLY_MULT: reg_rdata <= mult_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // Checks
   chk_halt_sticky: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      st_reg == PEM_ST_HALT |=> st_reg == PEM_ST_HALT) else $error("halt state left");
   chk_timeout_halts: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      timeout |=> st_reg == PEM_ST_HALT ##1 !driver_enable) else $error("timeout did not halt");
   chk_tmo_flag: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      timeout |=> tmo_flag_reg) else $error("timeout flag not set");
   chk_por_init: assert property (@(posedge clk) disable iff (!rstn)
      por_reg |=> st_reg == PEM_ST_INIT && !driver_enable) else $error("reset not held");
   chk_latch_stop: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      latch_fault && in_drive |=> st_reg == PEM_ST_HALT) else $error("latch fault ignored");
   chk_ov_block: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      st_reg == PEM_ST_INIT && ov_det_reg |=> st_reg == PEM_ST_INIT) else $error("entry with ov");
   chk_flag_set_wins: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      prt_evt[0] |=> prt_flag_reg[0]) else $error("event lost");
   chk_alert_follow: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      prt_alert |=> !alert_n) else $error("alert not driven");
   chk_alert_quiet: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      !prt_alert && !lnk_alert && !wrd_alert |=> alert_n) else $error("alert without event");
   chk_restart_flag: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      link_err |=> lnk_flag_reg[3]) else $error("restart flag missing");
   // A pause in power-control mode lasts one cycle; the last allowed fault must halt for good
   chk_atpc_resume: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      st_reg == PEM_ST_PAUSE && atpc |=> st_reg == PEM_ST_DRIVE) else $error("no restart in power control");
   chk_fault_limit: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      restart_evt && count_full |=> st_reg == PEM_ST_HALT) else $error("fault limit ignored");
   chk_duty_stop: assert property (@(posedge clk) disable iff (!rstn || por_reg)
      md_det && in_drive |=> st_reg != PEM_ST_DRIVE) else $error("duty fault ignored");
endmodule
`default_nettype wire

//--- sim/pem_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller on the far side of the register path; strobes move 1 ns after the edge
module pem_mcu_model (
   input wire logic clk,
   output var pem_pkg::pem_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata
);
   import pem_pkg::*;
   initial reg_req = '0;
   // One-cycle write; address and data are scrambled afterwards so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // One-cycle read; data is registered at the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pem_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, supply_low = 1'b0, standby_n = 1'b1, drive_request = 1'b0;
   pem_mode_e mode = PEM_MODE_MCU;
   pem_reg_req_s reg_req;
   pem_sense_s sense = '0;
   pem_link_s link = '0;
   logic [9:0] duty_now = 10'h020;
   logic [7:0] reg_rdata, rd_val;
   logic driver_enable, restore_initial_duty, alert_n;
   int bad_count = 0, check_count = 0, cyc = 0;
   always #4 clk = ~clk;
   // Short timer figures: code 0 ends at 30 cycles, code 1 at 80
   pem_monitor #(.TMO_MS_0(3), .TMO_MS_1(8), .TMO_MS_2(12), .TMO_MS_3(16), .MS_TICK(10)) u_dut (
      .clk(clk), .rstn(rstn), .supply_low(supply_low), .standby_n(standby_n), .mode(mode),
      .drive_request(drive_request), .reg_req(reg_req), .reg_rdata(reg_rdata), .sense(sense),
      .duty_now(duty_now), .link(link), .driver_enable(driver_enable),
      .restore_initial_duty(restore_initial_duty), .alert_n(alert_n));
   pem_mcu_model u_mcu (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      u_mcu.rd(a, rd_val);
      chk_byte(rd_val, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait on driver_enable (0) or alert_n (1); a miss shows as a mismatch
   task automatic wait_pin(input int which, input logic val, input int lim);
      int n;
      n = 0;
      while (((which == 0) ? driver_enable : alert_n) !== val && n < lim) begin
         idle(1);
         n++;
      end
      chk_bit((which == 0) ? driver_enable : alert_n, val);
   endtask
   task automatic pulse(input pem_link_s p);
      @(posedge clk);
      #1 link = p;
      @(posedge clk);
      #1 link = '0;
   endtask
   // Standby pin low long enough to pass the synchronizer, then settle
   task automatic dev_reset;
      drive_request = 1'b0;
      standby_n = 1'b0;
      idle(6);
      standby_n = 1'b1;
      idle(6);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Whole run needs about 650 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      idle(5);
      rstn = 1'b1;
      idle(6);
      chk_bit(driver_enable, 1'b0);
      chk_bit(alert_n, 1'b1);
      chk_rd(OFF_PROT_FLAGS, 8'h00);
      chk_rd(8'h30, 8'h00);
      $display("test reset_state done");
      // Max duty stop in controller mode, restart once duty is back under the limit
      u_mcu.wr(OFF_TIMER_CFG, 8'h20);
      u_mcu.wr(OFF_MAXDUTY_LO, 8'h40);
      chk_rd(OFF_MAXDUTY_LO, 8'h40);
      u_mcu.wr(OFF_PROT_EN, 8'h10);
      u_mcu.wr(OFF_PROT_CTRL, 8'h02);
      drive_request = 1'b1;
      wait_pin(0, 1'b1, 50);
      idle(60);
      chk_bit(driver_enable, 1'b1);
      duty_now = 10'h041;
      wait_pin(0, 1'b0, FAST_CYC + 4);
      wait_pin(1, 1'b0, 4);
      chk_rd(OFF_PROT_FLAGS, 8'h10);
      duty_now = 10'h020;
      wait_pin(0, 1'b1, 50);
      u_mcu.wr(OFF_PROT_CTRL, 8'h03);
      wait_pin(1, 1'b1, 4);
      chk_rd(OFF_PROT_FLAGS, 8'h00);
      $display("test max_duty done");
      // Packet flag with alert disabled, then enabled, then reset racing a new packet
      u_mcu.wr(OFF_LINK_FLAGS, 8'h00);
      pulse('{pkt_rx: 1'b1, default: 1'b0});
      idle(3);
      chk_bit(alert_n, 1'b1);
      chk_rd(OFF_LINK_FLAGS, 8'h02);
      u_mcu.wr(OFF_LINK_FLAGS, 8'h81);
      pulse('{pkt_rx: 1'b1, default: 1'b0});
      wait_pin(1, 1'b0, 4);
      fork
         u_mcu.wr(OFF_LINK_FLAGS, 8'h81);
         pulse('{pkt_rx: 1'b1, default: 1'b0});
      join
      idle(3);
      chk_bit(alert_n, 1'b0);
      u_mcu.wr(OFF_LINK_FLAGS, 8'h81);
      wait_pin(1, 1'b1, 4);
      mode = PEM_MODE_ATPC;
      pulse('{wr_done: 1'b1, default: 1'b0});
      wait_pin(1, 1'b0, 4);
      chk_rd(OFF_LINK_FLAGS, 8'h84);
      mode = PEM_MODE_MCU;
      $display("test link_events done");
      // Short circuit latches the driver off until a standby reset
      u_mcu.wr(OFF_TIMER_CFG, 8'h20);
      sense.short_det = 1'b1;
      wait_pin(0, 1'b0, FAST_CYC + 4);
      sense.short_det = 1'b0;
      idle(40);
      chk_bit(driver_enable, 1'b0);
      chk_rd(OFF_PROT_FLAGS, 8'h08);
      dev_reset();
      $display("test short_latch done");
      // Session timer with code 1 must outlast code 0 and then hold the halt
      u_mcu.wr(OFF_TIMER_CFG, 8'h40);
      drive_request = 1'b1;
      wait_pin(0, 1'b1, 50);
      idle(45);
      chk_bit(driver_enable, 1'b1);
      wait_pin(0, 1'b0, 60);
      chk_rd(OFF_IND_STATUS, 8'h20);
      idle(20);
      chk_bit(driver_enable, 1'b0);
      supply_low = 1'b1;
      idle(6);
      chk_rd(OFF_IND_STATUS, 8'h00);
      supply_low = 1'b0;
      idle(6);
      wait_pin(0, 1'b1, 50);
      $display("test session_timer done");
      // Power-control mode: link error restarts with restored duty, then a hot sensor uses up the fault limit
      dev_reset();
      mode = PEM_MODE_ATPC;
      u_mcu.wr(OFF_TIMER_CFG, 8'h20);
      u_mcu.wr(OFF_MAXDUTY_HI, 8'h03);
      u_mcu.wr(OFF_T1_LO, 8'h80);
      drive_request = 1'b1;
      wait_pin(0, 1'b1, 50);
      pulse('{access_fail: 1'b1, default: 1'b0});
      chk_bit(driver_enable, 1'b0);
      idle(1);
      chk_bit(restore_initial_duty, 1'b1);
      chk_bit(driver_enable, 1'b1);
      pulse('{rd_done: 1'b1, default: 1'b0});
      wait_pin(1, 1'b0, 4);
      chk_rd(OFF_LINK_FLAGS, 8'h18);
      sense.therm1_code = 12'h0FF;
      idle(60);
      chk_bit(driver_enable, 1'b0);
      chk_rd(OFF_PROT_FLAGS, 8'h01);
      sense.therm1_code = 12'h000;
      idle(10);
      chk_bit(driver_enable, 1'b0);
      $display("test atpc_restart done");
      summarize();
   end
endmodule
`default_nettype wire
